// ### bench/sioc_switches.sv
// Switch model driving the input terminals.
`timescale 1ns/1ps
module sioc_switches (
	// Clock and wanted levels.
	input wire i_clk,
	input wire [9:0] i_lvl,
	// Terminal levels.
	output logic [9:0] o_pin = 10'h0
);
	// Contacts follow one edge later and stay as long as asked.
	always @(posedge i_clk) o_pin <= i_lvl;
endmodule // sioc_switches

// ### bench/sioc_top_properties.sv
// Port assertions of the servo conditioning block.
`timescale 1ns/1ps
module sioc_chk #(
	parameter LS_TICKS = 5
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_rst,
	// Bus and lines.
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire o_wb_ack,
	input wire [9:0] i_physical_input_line,
	input wire [127:0] o_in_func_active,
	input wire [9:0] o_in_line_active
);
	logic [9:0] pin_r;
	logic [5:0] hist_r;
	logic [5:0] wr_r;
	logic [15:0] run_r;
	logic [15:0] prev_r;
	wire wr = i_wb_cyc & i_wb_we;
	// Six cycles of causes, and how long line one last stayed steady.
	always @(posedge i_clk) begin
		pin_r <= i_physical_input_line;
		hist_r <= {hist_r[4:0], i_rst | wr | (i_physical_input_line != pin_r)};
		wr_r <= {wr_r[4:0], wr};
		if (i_rst | (i_physical_input_line[0] != pin_r[0])) begin
			prev_r <= i_rst ? 16'h0 : run_r;
			run_r <= 16'h0;
		end else if (run_r != 16'hffff) begin
			run_r <= run_r + 16'h1;
		end
	end
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	ack_resp_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
	ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("stray ack");
	ack_idle_a: assert property (!i_wb_stb |=> !o_wb_ack) else $error("ack while idle");
	line_cause_a: assert property (!$stable(o_in_line_active) |-> |hist_r)
		else $error("line moved alone");
	func_cause_a: assert property (!$stable(o_in_func_active) |-> |hist_r)
		else $error("function moved alone");
	func_idle_a: assert property ((o_in_line_active == 10'h0) [*3] |-> o_in_func_active == 128'h0)
		else $error("function without line");
	slow_qual_a: assert property ($rose(o_in_line_active[0]) && wr_r == 6'h0 |-> prev_r >= (LS_TICKS - 1) * 10)
		else $error("slow line qualified early");
	cover property ($rose(o_in_line_active[0]));
	cover property ($rose(o_in_line_active[8]));
	cover property (o_wb_ack && i_wb_we);
endmodule // sioc_chk
bind sioc_top sioc_chk #(.LS_TICKS(LS_TICKS)) sioc_chk_inst (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack), .i_physical_input_line(i_physical_input_line),
	.o_in_func_active(o_in_func_active), .o_in_line_active(o_in_line_active));

// ### bench/sioc_top_tb.sv
// Self-checking bench of the servo conditioning block.
`timescale 1ns/1ps
`include "sioc_consts.vh"
module sioc_top_tb;
	logic i_clk, i_rst, req, we, ack, ea, eb, ez;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wd, rd, v;
	logic [9:0] lvl, pin, lact;
	logic [127:0] fst, fact;
	logic [2:0] ol;
	integer num_errors = 0, check_count = 0, seed = 32'h157b, i, m, n, f, r, ln;
	// Condition codes that fire on a rise and on a fall.
	localparam logic [4:0] UP = 5'b10110, DN = 5'b11001;
	// Short counts: five slow ticks, three fast ticks.
	sioc_top #(.LS_TICKS(5), .HS_TICKS(3)) sioc_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(req),
		.i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(rd),
		.o_wb_ack(ack), .i_physical_input_line(pin), .i_out_func_state(fst), .i_enc_a(ea), .i_enc_b(eb),
		.i_enc_z(ez), .o_in_func_active(fact), .o_in_line_active(lact), .o_out_line(ol));
	sioc_switches sioc_switches_inst (.i_clk(i_clk), .i_lvl(lvl), .o_pin(pin));
	// Clock of 100 ns.
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %h not %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("%0d errors in %0d checks", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One classic cycle, entered just after an edge; read data lands in v.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		req <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		for (k = 0; k < 20 && ack !== 1'b1; k++)
			@(posedge i_clk);
		if (k == 20) begin
			num_errors++;
			tally_and_finish;
		end
		v = rd;
		req <= 1'b0;
		@(posedge i_clk);
	endtask
	// Moves one switch, then counts rises of that line's activity.
	task automatic flip(input integer l, input logic lv, input integer t);
		logic p;
		p = lact[l];
		r = 0;
		lvl[l] <= lv;
		repeat (t) begin
			@(posedge i_clk);
			r += lact[l] & ~p;
			p = lact[l];
		end
	endtask
	// Forced bit or mapped state, then inverted; encoder routing takes lines one and two.
	function automatic logic [2:0] exp_out(input integer n, input integer m, input integer f);
		logic [2:0] o;
		for (int j = 0; j < 3; j++)
			o[j] = (f[8+j] ? f[j] : fst[n[8*j +: 7]]) ^ m[j];
		if (m[8])
			o[1:0] = {eb ^ ez, ea};
		return o;
	endfunction
	initial begin
		{req, we, ea, eb, ez, adr, wd, lvl, fst} = '0;
		sel = 4'hf;
		i_rst = 1'b1;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		// Reset values, and an unmapped place that reads zero.
		bus(0, 8'h00, 0);
		check(v, `SIOC_RST_FUNC0);
		bus(0, 8'h10, 0);
		check(v, 32'h11111111);
		bus(1, 8'h30, 32'hffffffff);
		bus(0, 8'h30, 0);
		check(v, 0);
		// Random forcing by mask and by communication bits.
		for (i = 0; i < 8; i++) begin
			m = $random(seed) & 32'h3ff;
			n = $random(seed) & 32'h3ff;
			bus(1, 8'h18, m);
			bus(1, 8'h1c, n);
			check(lact, m | n);
			bus(0, 8'h28, 0);
			check(v, m | n);
			check({fact[42], fact[1]}, (m | n) & 3);
		end
		bus(1, 8'h18, 0);
		bus(1, 8'h1c, 0);
		// Only the low byte lane of the forcing mask is written.
		sel <= 4'h1;
		bus(1, 8'h18, 32'hffffffff);
		sel <= 4'hf;
		bus(0, 8'h18, 0);
		check(v, 32'h000000ff);
		bus(1, 8'h18, 0);
		// Random output mapping, inversion, forcing and encoder routing.
		for (i = 0; i < 12; i++) begin
			n = ($random(seed) & 32'h7f7f7f) | 32'h010101;
			m = $random(seed) & 32'h107;
			f = $random(seed) & 32'h707;
			bus(1, 8'h0c, n);
			bus(1, 8'h24, m);
			bus(1, 8'h20, f);
			fst <= {$random(seed), $random(seed), $random(seed), $random(seed)};
			r = $random(seed);
			{ea, eb, ez} <= r[2:0];
			repeat (3) @(posedge i_clk);
			check(ol, exp_out(n, m, f));
		end
		// Every condition on a slow and a fast line; high before low leaves the switches low.
		for (m = 4; m >= 0; m--) begin
			bus(1, 8'h10, m);
			bus(1, 8'h14, m);
			for (ln = 0; ln < 9; ln += 8) begin
				flip(ln, 1, 100);
				check(r, UP[m]);
				flip(ln, 0, 100);
				check(r, DN[m]);
			end
		end
		// A fall after a brief high: too short for the slow line, enough for the fast one.
		bus(1, 8'h10, 3);
		bus(1, 8'h14, 3);
		for (ln = 0; ln < 9; ln += 8) begin
			flip(ln, 1, ln ? 45 : 15);
			flip(ln, 0, 100);
			check(r, ln ? 1 : 0);
		end
		tally_and_finish;
	end
endmodule // sioc_top_tb

// ### common/sioc_consts.vh
// Constants and register map of the servo input/output conditioning block.
// Summary of operation
// RULE1: Ten input lines, each mapped to function code.
// RULE2: Active condition chosen per input line independently.
// RULE3: Active if qualified level, comm force, or mask.
// RULE4: Three output lines, each mapped to function code.
// RULE5: Per-output active level and forced-output mask override.
// RULE6: Lines 1-8 low speed, 9-10 high speed.
// RULE7: Low speed needs prior level over 3 ms.
// RULE8: High speed needs prior level over 0.25 ms.
// RULE9: Five conditions: low, high, rise, fall, both edges.
// RULE10: Outputs 1 and 2 may carry encoder pulses.
// RULE11: Per-line tick counter restarts on level change.
`ifndef SIOC_CONSTS_VH
`define SIOC_CONSTS_VH
// Clock and qualification times.
`define SIOC_CLK_HZ 10000000
`define SIOC_TICK_DIV 10
`define SIOC_LS_TIME_US 3000
`define SIOC_HS_TIME_US 250
// Ticks of 1 us; more than the time means count reaches time plus one.
`define SIOC_TICK_HZ (`SIOC_CLK_HZ / `SIOC_TICK_DIV)
`define SIOC_LS_TICKS ((`SIOC_LS_TIME_US * (`SIOC_TICK_HZ / 1000000)) + 1)
`define SIOC_HS_TICKS ((`SIOC_HS_TIME_US * (`SIOC_TICK_HZ / 1000000)) + 1)
// Active condition encodings.
`define SIOC_COND_LOW 3'h0
`define SIOC_COND_HIGH 3'h1
`define SIOC_COND_RISE 3'h2
`define SIOC_COND_FALL 3'h3
`define SIOC_COND_BOTH 3'h4
// Register byte addresses.
`define SIOC_ADR_IN_FUNC0 8'h00
`define SIOC_ADR_IN_FUNC1 8'h04
`define SIOC_ADR_IN_FUNC2 8'h08
`define SIOC_ADR_OUT_FUNC 8'h0c
`define SIOC_ADR_IN_COND0 8'h10
`define SIOC_ADR_IN_COND1 8'h14
`define SIOC_ADR_FORCE_IN 8'h18
`define SIOC_ADR_COMM_IN 8'h1c
`define SIOC_ADR_FORCE_OUT 8'h20
`define SIOC_ADR_OUT_CTRL 8'h24
`define SIOC_ADR_IN_STATE 8'h28
`define SIOC_ADR_OUT_STATE 8'h2c
// Reset values.
`define SIOC_RST_FUNC0 32'h00002a01
`define SIOC_RST_ZERO 32'h00000000
`endif

// ### design/sioc_qual.v
// One input line qualifier: persistence counter and condition detection.
`timescale 1ns/1ps
`include "sioc_consts.vh"
module sioc_qual #(
	parameter TICKS = 3001
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_rst,
	input wire i_tick,
	// Line and condition.
	input wire i_pin,
	input wire [2:0] i_cond,
	// Qualified active result.
	output reg o_active
);
	reg prev_r;
	reg [15:0] cnt_r;
	reg long_r;
	wire change = (i_pin != prev_r);
	wire long_now = long_r | (i_tick & (cnt_r + 16'h0001 >= TICKS[15:0]));
	// Count how long the level has stood; restart on every change.
	always @(posedge i_clk) begin
		if (i_rst) begin
			prev_r <= 1'b0;
			cnt_r <= 16'h0000;
			long_r <= 1'b0;
			o_active <= 1'b0;
		end else begin
			prev_r <= i_pin;
			if (change) begin
				cnt_r <= 16'h0000; // RULE11
				long_r <= 1'b0;
			end else if (i_tick && !long_r) begin
				cnt_r <= cnt_r + 16'h0001;
				long_r <= long_now; // RULE7 RULE8
			end
			// Conditions are honoured only after a long opposite level.
			case (i_cond)
			`SIOC_COND_LOW: begin
				if (change && !i_pin && long_r)
					o_active <= 1'b1;
				else if (i_pin)
					o_active <= 1'b0; // RULE9
			end
			`SIOC_COND_HIGH: begin
				if (change && i_pin && long_r)
					o_active <= 1'b1;
				else if (!i_pin)
					o_active <= 1'b0; // RULE9
			end
			`SIOC_COND_RISE: o_active <= change && i_pin && long_r; // RULE9
			`SIOC_COND_FALL: o_active <= change && !i_pin && long_r; // RULE9
			`SIOC_COND_BOTH: o_active <= change && long_r; // RULE9
			default: o_active <= 1'b0;
			endcase
		end
	end
endmodule // sioc_qual

// ### design/sioc_tick.v
// Tick divider producing a one-cycle enable every N clocks.
`timescale 1ns/1ps
module sioc_tick #(
	parameter DIV = 10
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_rst,
	// Tick enable.
	output reg o_tick
);
	reg [15:0] cnt_r;
	// Count up and pulse at wrap.
	always @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r <= 16'h0000;
			o_tick <= 1'b0;
		end else if (cnt_r == DIV[15:0] - 16'h0001) begin
			cnt_r <= 16'h0000;
			o_tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			o_tick <= 1'b0;
		end
	end
endmodule // sioc_tick

// ### design/sioc_top.v
// Input and output conditioning of the servo drive with a Wishbone slave.
`timescale 1ns/1ps
`include "sioc_consts.vh"
module sioc_top #(
	parameter N_IN = 10,
	parameter N_OUT = 3,
	parameter N_LS = 8,
	parameter LS_TICKS = `SIOC_LS_TICKS,
	parameter HS_TICKS = `SIOC_HS_TICKS
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_rst,
	// Wishbone classic slave.
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output reg [31:0] o_wb_dat,
	output reg o_wb_ack,
	// Physical input lines.
	input wire [9:0] i_physical_input_line,
	// Internal output function states, indexed by function code.
	input wire [127:0] i_out_func_state,
	// Encoder pulses A, B and Z.
	input wire i_enc_a,
	input wire i_enc_b,
	input wire i_enc_z,
	// Input function results, indexed by function code.
	output reg [127:0] o_in_func_active,
	// Active line states: qualified, comm forced or masked.
	output wire [9:0] o_in_line_active,
	// Physical output lines.
	output reg [2:0] o_out_line
);
	// Configuration registers.
	reg [6:0] in_func_r [0:9];
	reg [6:0] out_func_r [0:2];
	reg [2:0] in_cond_r [0:9];
	reg [9:0] forced_input_mask_r;
	reg [9:0] comm_in_r;
	reg [2:0] forced_output_mask_r;
	reg [2:0] force_en_r;
	reg [2:0] out_pol_r;
	reg encoder_pulse_output_select_r;
	wire tick;
	wire [9:0] qual;
	wire [9:0] line_act;
	wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire wr = req & i_wb_we;
	integer k;
	integer fi;
	integer oi;

	sioc_tick #(
		.DIV(`SIOC_TICK_DIV)
	) u_tick (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.o_tick(tick)
	);

	// One qualifier per input line; speed class picks the time.
	genvar g;
	generate
		for (g = 0; g < N_IN; g = g + 1) begin : g_in
			sioc_qual #(
				.TICKS((g < N_LS) ? LS_TICKS : HS_TICKS) // RULE6
			) u_q (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_tick(tick),
				.i_pin(i_physical_input_line[g]),
				.i_cond(in_cond_r[g]), // RULE2
				.o_active(qual[g])
			);
			assign line_act[g] = qual[g] | comm_in_r[g] | forced_input_mask_r[g]; // RULE3
		end
	endgenerate
	assign o_in_line_active = line_act;

	// Register writes, byte lane by lane where fields allow.
	always @(posedge i_clk) begin
		if (i_rst) begin
			for (k = 0; k < 10; k = k + 1) begin
				in_func_r[k] <= 7'h00;
				in_cond_r[k] <= `SIOC_COND_HIGH;
			end
			in_func_r[0] <= 7'h01;
			in_func_r[1] <= 7'h2a;
			for (k = 0; k < 3; k = k + 1)
				out_func_r[k] <= 7'h00;
			forced_input_mask_r <= 10'h000;
			comm_in_r <= 10'h000;
			forced_output_mask_r <= 3'h0;
			force_en_r <= 3'h0;
			out_pol_r <= 3'h0;
			encoder_pulse_output_select_r <= 1'b0;
		end else if (wr) begin
			case (i_wb_adr)
			`SIOC_ADR_IN_FUNC0, `SIOC_ADR_IN_FUNC1, `SIOC_ADR_IN_FUNC2: begin
				for (k = 0; k < 4; k = k + 1)
					if (i_wb_sel[k] && (i_wb_adr[3:2] * 4 + k) < 10)
						in_func_r[i_wb_adr[3:2] * 4 + k] <= i_wb_dat[k*8 +: 7]; // RULE1
			end
			`SIOC_ADR_OUT_FUNC: begin
				for (k = 0; k < 3; k = k + 1)
					if (i_wb_sel[k])
						out_func_r[k] <= i_wb_dat[k*8 +: 7]; // RULE4
			end
			`SIOC_ADR_IN_COND0: begin
				for (k = 0; k < 8; k = k + 1)
					if (i_wb_sel[k/2])
						in_cond_r[k] <= i_wb_dat[k*4 +: 3]; // RULE2
			end
			`SIOC_ADR_IN_COND1: begin
				for (k = 0; k < 2; k = k + 1)
					if (i_wb_sel[0])
						in_cond_r[8+k] <= i_wb_dat[k*4 +: 3];
			end
			`SIOC_ADR_FORCE_IN: begin
				if (i_wb_sel[0])
					forced_input_mask_r[7:0] <= i_wb_dat[7:0];
				if (i_wb_sel[1])
					forced_input_mask_r[9:8] <= i_wb_dat[9:8];
			end
			`SIOC_ADR_COMM_IN: begin
				if (i_wb_sel[0])
					comm_in_r[7:0] <= i_wb_dat[7:0];
				if (i_wb_sel[1])
					comm_in_r[9:8] <= i_wb_dat[9:8];
			end
			`SIOC_ADR_FORCE_OUT: begin
				if (i_wb_sel[0])
					forced_output_mask_r <= i_wb_dat[2:0];
				if (i_wb_sel[1])
					force_en_r <= i_wb_dat[10:8];
			end
			`SIOC_ADR_OUT_CTRL: begin
				if (i_wb_sel[0])
					out_pol_r <= i_wb_dat[2:0];
				if (i_wb_sel[1])
					encoder_pulse_output_select_r <= i_wb_dat[8];
			end
			default: begin
			end
			endcase
		end
	end

	// Read mux and single-cycle acknowledge; unmapped reads return zero.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else begin
			o_wb_ack <= req;
			o_wb_dat <= 32'h00000000;
			if (req && !i_wb_we) begin
				case (i_wb_adr)
				`SIOC_ADR_IN_FUNC0: o_wb_dat <= {1'b0, in_func_r[3], 1'b0, in_func_r[2],
					1'b0, in_func_r[1], 1'b0, in_func_r[0]};
				`SIOC_ADR_IN_FUNC1: o_wb_dat <= {1'b0, in_func_r[7], 1'b0, in_func_r[6],
					1'b0, in_func_r[5], 1'b0, in_func_r[4]};
				`SIOC_ADR_IN_FUNC2: o_wb_dat <= {16'h0000, 1'b0, in_func_r[9], 1'b0, in_func_r[8]};
				`SIOC_ADR_OUT_FUNC: o_wb_dat <= {8'h00, 1'b0, out_func_r[2], 1'b0, out_func_r[1],
					1'b0, out_func_r[0]};
				`SIOC_ADR_IN_COND0: o_wb_dat <= {1'b0, in_cond_r[7], 1'b0, in_cond_r[6], 1'b0, in_cond_r[5],
					1'b0, in_cond_r[4], 1'b0, in_cond_r[3], 1'b0, in_cond_r[2], 1'b0, in_cond_r[1],
					1'b0, in_cond_r[0]};
				`SIOC_ADR_IN_COND1: o_wb_dat <= {24'h000000, 1'b0, in_cond_r[9], 1'b0, in_cond_r[8]};
				`SIOC_ADR_FORCE_IN: o_wb_dat <= {22'h000000, forced_input_mask_r};
				`SIOC_ADR_COMM_IN: o_wb_dat <= {22'h000000, comm_in_r};
				`SIOC_ADR_FORCE_OUT: o_wb_dat <= {21'h000000, force_en_r, 5'h00, forced_output_mask_r};
				`SIOC_ADR_OUT_CTRL: o_wb_dat <= {23'h000000, encoder_pulse_output_select_r, 5'h00, out_pol_r};
				`SIOC_ADR_IN_STATE: o_wb_dat <= {22'h000000, line_act};
				`SIOC_ADR_OUT_STATE: o_wb_dat <= {29'h00000000, o_out_line};
				default: o_wb_dat <= 32'h00000000;
				endcase
			end
		end
	end

	// Route each active line with a nonzero code onto its input function code.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_in_func_active <= 128'h0;
		end else begin
			o_in_func_active <= 128'h0;
			for (fi = 0; fi < 10; fi = fi + 1)
				if (line_act[fi] && in_func_r[fi] != 7'h00)
					o_in_func_active[in_func_r[fi]] <= 1'b1; // RULE1
		end
	end

	// Output lines: function or forced bit, polarity, encoder override.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_out_line <= 3'h0;
		end else begin
			for (oi = 0; oi < 3; oi = oi + 1)
				o_out_line[oi] <= (force_en_r[oi] ? forced_output_mask_r[oi]
					: i_out_func_state[out_func_r[oi]]) ^ out_pol_r[oi]; // RULE4 RULE5
			if (encoder_pulse_output_select_r) begin
				o_out_line[0] <= i_enc_a; // RULE10
				o_out_line[1] <= i_enc_b ^ i_enc_z;
			end
		end
	end
endmodule // sioc_top
